// File: rtl/sam_cfg.svh
// constants for the spi header decoder and output pin configuration
// assumes inclusion by rtl files only
`ifndef SAM_CFG_SVH
`define SAM_CFG_SVH
`define SAM_HDR_RW_BIT 7
`define SAM_HDR_BURST_BIT 6
`define SAM_ADDR_MSB 5
`define SAM_CFG_LAST 6'h2E
`define SAM_STROBE_FIRST 6'h30
`define SAM_STROBE_LAST 6'h3D
`define SAM_FIFO_ADDR 6'h3F
`define SAM_OUT2_OFS 6'h00
`define SAM_OUT1_OFS 6'h01
`define SAM_DS_BIT 7
`define SAM_INV_BIT 6
`define SAM_SEL_MSB 5
`define SAM_OUT2_RST 8'h29
`define SAM_OUT1_RST 8'h2E
`define SAM_SEL_CHIP_RDY 6'h29
`define SAM_SEL_TRISTATE 6'h2E
`define SAM_STB_NOP 6'h3D
`endif

// File: rtl/sam_dec_if.sv
// header decode results passed from decoder to the register bank
// assumes a single mclk domain
`timescale 1ns/1ps
interface sam_dec_if;
  import sam_pkg::*;
  logic [5:0] addr;
  logic is_read;
  logic is_burst;
  logic valid;
  sam_target_e target;
  modport dec (output addr, output is_read, output is_burst, output valid, output target);
  modport use_side (input addr, input is_read, input is_burst, input valid, input target);
endinterface

// File: rtl/sam_hdr_decode.sv
// combinational decode of one header byte into access kind and target
// assumes header byte is already captured on mclk
`timescale 1ns/1ps
`include "sam_cfg.svh"
module sam_hdr_decode (
  input wire logic [7:0] header,
  sam_dec_if.dec dec
);
  import sam_pkg::*;
  logic [5:0] a;
  always_comb begin
    a = header[`SAM_ADDR_MSB:0];
    dec.addr = a;
    dec.is_read = header[`SAM_HDR_RW_BIT];
    dec.is_burst = header[`SAM_HDR_BURST_BIT];
    dec.valid = 1'b0;
    dec.target = SAM_TGT_CONFIG;
    if (a <= `SAM_CFG_LAST) begin
      dec.valid = 1'b1;
    end else if (a >= `SAM_STROBE_FIRST && a <= `SAM_STROBE_LAST) begin
      dec.valid = 1'b1;
      dec.target = (header[`SAM_HDR_RW_BIT] && header[`SAM_HDR_BURST_BIT]) ?
        SAM_TGT_STATUS : SAM_TGT_STROBE;
      if (!header[`SAM_HDR_RW_BIT] && header[`SAM_HDR_BURST_BIT]) begin
        dec.valid = 1'b0;
      end
    end else if (a == `SAM_FIFO_ADDR && header[`SAM_HDR_RW_BIT]) begin
      dec.valid = 1'b1;
      dec.target = SAM_TGT_FIFO;
    end
  end
endmodule

// File: rtl/sam_pkg.sv
// types for the spi header decoder
// assumes sam_cfg.svh constants alongside
package sam_pkg;
  typedef enum logic [1:0] {
    SAM_TGT_CONFIG,
    SAM_TGT_STROBE,
    SAM_TGT_STATUS,
    SAM_TGT_FIFO
  } sam_target_e;
  typedef enum logic [1:0] {
    SAM_ST_HEADER,
    SAM_ST_DATA
  } sam_state_e;
endpackage

// File: rtl/sam_spi_map.sv
// spi header decode, access routing and output pin configuration registers
// assumes byte strobes from an spi shifter on mclk; first byte of a frame is the header
// Notes on behaviour
// - header: address plus burst and read flags
// - 0x00-0x2E config, read/write, burst increments
// - 0x30-0x3D strobes or status; 0x3F fifo
// - bit 6 inverts pin, resets zero
// - output2 select resets 101001, bit7 reads zero
// - output1 select resets 101110, tristate
// - output1 bit 7 sets drive strength
// - no-op strobe still pulses strobe_pulse and loads strobe_code
`timescale 1ns/1ps
`include "sam_cfg.svh"
module sam_spi_map (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic frame_active,
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  input wire logic [7:0] status_byte,
  input wire logic [7:0] fifo_rd_data,
  input wire logic [7:0] status_rd_data,
  input wire logic [7:0] ext_cfg_rd_data,
  input wire logic out2_signal,
  input wire logic out1_signal,
  output logic [7:0] byte_out,
  output logic [5:0] cur_addr,
  output logic strobe_pulse,
  output logic [5:0] strobe_code,
  output logic status_rd_pulse,
  output logic fifo_rd_pulse,
  output logic ext_cfg_wr_pulse,
  output logic [7:0] ext_cfg_wr_data,
  output logic general_output_2,
  output logic general_output_2_oe_n,
  output logic general_output_1,
  output logic general_output_1_oe_n,
  output logic output_drive_strength
);
  import sam_pkg::*;
  sam_dec_if dec_if ();
  logic [7:0] hdr_byte;
  sam_state_e state_reg, state_next;
  logic [5:0] addr_reg, addr_next;
  logic rd_reg, rd_next;
  logic burst_reg, burst_next;
  logic valid_reg, valid_next;
  sam_target_e tgt_reg, tgt_next;
  logic [7:0] out2_reg, out2_next;
  logic [7:0] out1_reg, out1_next;
  logic [7:0] byte_out_reg, byte_out_next;
  logic strobe_reg, strobe_next;
  logic [5:0] strobe_code_reg, strobe_code_next;
  logic status_rd_reg, status_rd_next;
  logic fifo_rd_reg, fifo_rd_next;
  logic ext_wr_reg, ext_wr_next;
  logic [7:0] ext_wdata_reg, ext_wdata_next;
  logic pin2_reg, pin2_next;
  logic pin2_oe_n_reg, pin2_oe_n_next;
  logic pin1_reg, pin1_next;
  logic pin1_oe_n_reg, pin1_oe_n_next;

  // read data for a config address; unused and reserved addresses give zero
  function automatic logic [7:0] cfg_read(input logic [5:0] a, input logic [7:0] o2,
      input logic [7:0] o1, input logic [7:0] ext);
    logic [7:0] r;
    r = 8'h00;
    if (a == `SAM_OUT2_OFS) begin
      r = {1'b0, o2[6:0]};
    end else if (a == `SAM_OUT1_OFS) begin
      r = o1;
    end else if (a <= `SAM_CFG_LAST) begin
      r = ext;
    end
    return r;
  endfunction

  // one pin value and enable from its config byte
  function automatic logic [1:0] pin_drive(input logic [7:0] cfg, input logic sig);
    logic [1:0] r;
    r = {1'b1, 1'b0};
    if (cfg[`SAM_SEL_MSB:0] != `SAM_SEL_TRISTATE) begin
      r = {1'b0, sig ^ cfg[`SAM_INV_BIT]};
    end
    return r;
  endfunction

  assign hdr_byte = byte_in;

  sam_hdr_decode u_dec (
    .header(hdr_byte),
    .dec(dec_if.dec)
  );

  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    rd_next = rd_reg;
    burst_next = burst_reg;
    valid_next = valid_reg;
    tgt_next = tgt_reg;
    out2_next = out2_reg;
    out1_next = out1_reg;
    byte_out_next = byte_out_reg;
    strobe_next = 1'b0;
    strobe_code_next = strobe_code_reg;
    status_rd_next = 1'b0;
    fifo_rd_next = 1'b0;
    ext_wr_next = 1'b0;
    ext_wdata_next = ext_wdata_reg;
    if (!frame_active) begin
      state_next = SAM_ST_HEADER;
    end else if (byte_valid) begin
      case (state_reg)
        SAM_ST_HEADER: begin
          addr_next = dec_if.addr;
          rd_next = dec_if.is_read;
          burst_next = dec_if.is_burst;
          valid_next = dec_if.valid;
          tgt_next = dec_if.target;
          byte_out_next = status_byte;
          state_next = SAM_ST_DATA;
          if (dec_if.valid && dec_if.target == SAM_TGT_STROBE) begin
            // no-op still pulses; consumers treat its code as inert
            strobe_next = 1'b1;
            strobe_code_next = dec_if.addr;
          end
          if (dec_if.is_read && !dec_if.valid) begin
            byte_out_next = 8'h00;
          end
          if (dec_if.valid && dec_if.is_read) begin
            if (dec_if.target == SAM_TGT_CONFIG) begin
              byte_out_next = cfg_read(dec_if.addr, out2_reg, out1_reg, ext_cfg_rd_data);
            end else if (dec_if.target == SAM_TGT_STATUS) begin
              byte_out_next = status_rd_data;
              status_rd_next = 1'b1;
            end else if (dec_if.target == SAM_TGT_FIFO) begin
              byte_out_next = fifo_rd_data;
              fifo_rd_next = 1'b1;
            end
          end
        end
        SAM_ST_DATA: begin
          byte_out_next = 8'h00;
          if (valid_reg && !rd_reg && tgt_reg == SAM_TGT_CONFIG) begin
            if (addr_reg == `SAM_OUT2_OFS) begin
              out2_next = {1'b0, byte_in[6:0]};
            end else if (addr_reg == `SAM_OUT1_OFS) begin
              out1_next = byte_in;
            end else begin
              ext_wr_next = 1'b1;
              ext_wdata_next = byte_in;
            end
          end
          if (burst_reg && tgt_reg == SAM_TGT_CONFIG) begin
            addr_next = addr_reg + 6'h01;
            valid_next = valid_reg && (addr_reg < `SAM_CFG_LAST);
            if (valid_reg && rd_reg && addr_reg < `SAM_CFG_LAST) begin
              byte_out_next = cfg_read(addr_reg + 6'h01, out2_reg, out1_reg, ext_cfg_rd_data);
            end
          end else if (burst_reg && valid_reg && rd_reg && tgt_reg == SAM_TGT_FIFO) begin
            byte_out_next = fifo_rd_data;
            fifo_rd_next = 1'b1;
          end else begin
            valid_next = 1'b0;
          end
        end
        default: begin
          state_next = SAM_ST_HEADER;
        end
      endcase
    end
  end

  always_comb begin
    {pin2_oe_n_next, pin2_next} = pin_drive(out2_reg, out2_signal);
    {pin1_oe_n_next, pin1_next} = pin_drive(out1_reg, out1_signal);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= SAM_ST_HEADER;
      addr_reg <= 6'h00;
      rd_reg <= 1'b0;
      burst_reg <= 1'b0;
      valid_reg <= 1'b0;
      tgt_reg <= SAM_TGT_CONFIG;
      out2_reg <= `SAM_OUT2_RST;
      out1_reg <= `SAM_OUT1_RST;
      byte_out_reg <= 8'h00;
      strobe_reg <= 1'b0;
      strobe_code_reg <= 6'h00;
      status_rd_reg <= 1'b0;
      fifo_rd_reg <= 1'b0;
      ext_wr_reg <= 1'b0;
      ext_wdata_reg <= 8'h00;
      pin2_reg <= 1'b0;
      pin2_oe_n_reg <= 1'b1;
      pin1_reg <= 1'b0;
      pin1_oe_n_reg <= 1'b1;
    end else if (clk_en) begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      rd_reg <= rd_next;
      burst_reg <= burst_next;
      valid_reg <= valid_next;
      tgt_reg <= tgt_next;
      out2_reg <= out2_next;
      out1_reg <= out1_next;
      byte_out_reg <= byte_out_next;
      strobe_reg <= strobe_next;
      strobe_code_reg <= strobe_code_next;
      status_rd_reg <= status_rd_next;
      fifo_rd_reg <= fifo_rd_next;
      ext_wr_reg <= ext_wr_next;
      ext_wdata_reg <= ext_wdata_next;
      pin2_reg <= pin2_next;
      pin2_oe_n_reg <= pin2_oe_n_next;
      pin1_reg <= pin1_next;
      pin1_oe_n_reg <= pin1_oe_n_next;
    end
  end

  assign byte_out = byte_out_reg;
  assign cur_addr = addr_reg;
  assign strobe_pulse = strobe_reg;
  assign strobe_code = strobe_code_reg;
  assign status_rd_pulse = status_rd_reg;
  assign fifo_rd_pulse = fifo_rd_reg;
  assign ext_cfg_wr_pulse = ext_wr_reg;
  assign ext_cfg_wr_data = ext_wdata_reg;
  assign general_output_2 = pin2_reg;
  assign general_output_2_oe_n = pin2_oe_n_reg;
  assign general_output_1 = pin1_reg;
  assign general_output_1_oe_n = pin1_oe_n_reg;
  assign output_drive_strength = out1_reg[`SAM_DS_BIT];
endmodule

// File: verification/sam_master_model.sv
// spi master stand-in: frames and byte strobes on mclk
// assumes the bench clock; drives 1 ns after rising edges
`timescale 1ns/1ps
module sam_master_model (
  input wire logic mclk,
  output logic frame_active,
  output logic byte_valid,
  output logic [7:0] byte_in
);
  initial begin
    frame_active = 1'b0;
    byte_valid = 1'b0;
    byte_in = 8'h00;
  end
  task automatic send(input logic [7:0] b);
    @(posedge mclk);
    #1;
    frame_active = 1'b1;
    byte_valid = 1'b1;
    byte_in = b;
    @(posedge mclk);
    #1;
    byte_valid = 1'b0;
    byte_in = ~b; // no stale byte on a released bus
  endtask
  task automatic close;
    @(posedge mclk);
    #1;
    frame_active = 1'b0;
  endtask
endmodule

// File: verification/sam_spi_map_sva.sv
// checker for header decode, access routing and pin config
// assumes binding to sam_spi_map, one mclk domain
`timescale 1ns/1ps
module sam_spi_map_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic frame_active,
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  input wire logic [7:0] status_byte,
  input wire logic [7:0] byte_out,
  input wire logic [5:0] cur_addr,
  input wire logic strobe_pulse,
  input wire logic [5:0] strobe_code,
  input wire logic status_rd_pulse,
  input wire logic fifo_rd_pulse,
  input wire logic ext_cfg_wr_pulse,
  input wire logic [7:0] ext_cfg_wr_data,
  input wire logic general_output_1_oe_n,
  input wire logic output_drive_strength
);
  logic take;
  logic hdr_reg;
  logic hdr_next;
  logic any_pulse;
  assign take = clk_en && frame_active && byte_valid;
  assign any_pulse = strobe_pulse || status_rd_pulse || fifo_rd_pulse || ext_cfg_wr_pulse;
  // tracks whether the next taken byte is a header
  always_comb begin
    hdr_next = hdr_reg;
    if (clk_en && !frame_active) hdr_next = 1'b1;
    else if (take) hdr_next = 1'b0;
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) hdr_reg <= 1'b1;
    else hdr_reg <= hdr_next;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence hdr_take;
    take && hdr_reg;
  endsequence
  sequence strobe_hdr;
    hdr_take ##0 (byte_in[5:0] >= 6'h30 && byte_in[5:0] <= 6'h3D);
  endsequence
  a_strobe_single: assert property (
    strobe_hdr ##0 !byte_in[6] |=> strobe_pulse && strobe_code == $past(byte_in[5:0]))
    else $error("single strobe header gave no strobe");
  a_status_burst: assert property (
    strobe_hdr ##0 byte_in[7:6] == 2'b11 |=> status_rd_pulse && !strobe_pulse)
    else $error("burst status read misrouted");
  a_burst_wr_ignored: assert property (
    strobe_hdr ##0 byte_in[7:6] == 2'b01 |=> !any_pulse)
    else $error("burst write to strobe space acted");
  a_fifo_read: assert property (
    hdr_take ##0 byte_in[7] && byte_in[5:0] == 6'h3F |=> fifo_rd_pulse)
    else $error("fifo read header gave no fifo pulse");
  a_write_hdr_status: assert property (
    hdr_take ##0 !byte_in[7]
    |=> byte_out == $past(status_byte) && cur_addr == $past(byte_in[5:0]))
    else $error("write header status or address wrong");
  a_pulse_cause: assert property (!take |=> !any_pulse)
    else $error("pulse without a taken byte");
  a_ext_write: assert property (
    ext_cfg_wr_pulse |-> $past(take) && ext_cfg_wr_data == $past(byte_in))
    else $error("config write data not the taken byte");
  a_drive_cause: assert property ($changed(output_drive_strength) |-> $past(take))
    else $error("drive strength changed with no write");
  a_out1_oe_cause: assert property (
    $changed(general_output_1_oe_n) |-> $past(take) || $past(take, 2))
    else $error("output 1 enable changed with no write");
endmodule
bind sam_spi_map sam_spi_map_chk chk (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
  .frame_active(frame_active), .byte_valid(byte_valid), .byte_in(byte_in),
  .status_byte(status_byte), .byte_out(byte_out), .cur_addr(cur_addr),
  .strobe_pulse(strobe_pulse), .strobe_code(strobe_code), .status_rd_pulse(status_rd_pulse),
  .fifo_rd_pulse(fifo_rd_pulse), .ext_cfg_wr_pulse(ext_cfg_wr_pulse),
  .ext_cfg_wr_data(ext_cfg_wr_data), .general_output_1_oe_n(general_output_1_oe_n),
  .output_drive_strength(output_drive_strength));

// File: verification/tb_top.sv
// bench: reset values, config access, bursts, strobes, status, fifo, reserved
// assumes the master model on the spi side and the bound checker
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic sig = 1'b1;
  logic ce = 1'b1;
  logic [7:0] stb = 8'hA5, ffd = 8'h3C, srd = 8'h5A, ecd = 8'h77;
  logic fa, bv, sp, srp, frp, ewp, g2, g2n, g1, g1n, ds;
  logic [7:0] bi, bo, ewd;
  logic [5:0] sc, ca;
  logic [5:0] codes [8] = '{6'h30, 6'h32, 6'h33, 6'h34, 6'h36, 6'h39, 6'h3A, 6'h3D};
  int miscompares = 0;
  int samples_checked = 0;
  always #25 mclk = ~mclk;
  sam_master_model m (.mclk(mclk), .frame_active(fa), .byte_valid(bv), .byte_in(bi));
  sam_spi_map dut (.mclk(mclk), .rst_n(rst_n), .clk_en(ce), .frame_active(fa),
    .byte_valid(bv), .byte_in(bi), .status_byte(stb), .fifo_rd_data(ffd),
    .status_rd_data(srd), .ext_cfg_rd_data(ecd), .out2_signal(sig), .out1_signal(sig),
    .byte_out(bo), .cur_addr(ca), .strobe_pulse(sp), .strobe_code(sc), .status_rd_pulse(srp),
    .fifo_rd_pulse(frp), .ext_cfg_wr_pulse(ewp), .ext_cfg_wr_data(ewd),
    .general_output_2(g2), .general_output_2_oe_n(g2n), .general_output_1(g1),
    .general_output_1_oe_n(g1n), .output_drive_strength(ds));
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic rd1(input logic [7:0] h, input string n, input logic [7:0] e);
    m.send(h);
    check(n, bo, e);
    m.close();
  endtask
  task automatic wr1(input logic [7:0] h, input logic [7:0] d);
    m.send(h);
    m.send(d);
    m.close();
  endtask
  task automatic t_reset;
    rd1(8'h80, "out2 cfg", 8'h29);
    rd1(8'h81, "out1 cfg", 8'h2E);
    check("oe1", {7'h00, g1n}, 8'h01);
    check("oe2", {7'h00, g2n}, 8'h00);
    check("pin2", {7'h00, g2}, 8'h01);
    check("ds", {7'h00, ds}, 8'h00);
  endtask
  task automatic t_write;
    wr1(8'h01, 8'hC5);
    check("ds set", {7'h00, ds}, 8'h01);
    rd1(8'h81, "out1 rb", 8'hC5);
    wr1(8'h00, 8'hE9);
    rd1(8'h80, "out2 rb", 8'h69);
    sig = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check("pin2 inv", {7'h00, g2}, 8'h01);
    check("pin1 inv", {7'h00, g1}, 8'h01);
    check("oe1 drive", {7'h00, g1n}, 8'h00);
  endtask
  task automatic t_burst;
    m.send(8'h40);
    m.send(8'h11);
    m.send(8'h2A);
    m.send(8'h5B);
    check("ext wr", {7'h00, ewp}, 8'h01);
    check("ext data", ewd, 8'h5B);
    m.close();
    m.send(8'hC0);
    check("burst rd0", bo, 8'h11);
    m.send(8'h00);
    check("burst rd1", bo, 8'h2A);
    check("burst addr", {2'b00, ca}, 8'h01);
    m.close();
  endtask
  task automatic t_strobes;
    // each of the eight listed strobe codes goes out as a single header, write and read alternating, after the config and burst tests
    foreach (codes[i]) begin
      m.send({i[0], 1'b0, codes[i]});
      check("strobe", {7'h00, sp}, 8'h01);
      check("code", {2'b00, sc}, {2'b00, codes[i]});
      check("status", bo, 8'hA5);
      m.close();
    end
    m.send(8'hFB);
    check("status rd", bo, 8'h5A);
    check("status pulse", {7'h00, srp}, 8'h01);
    m.close();
    m.send(8'h7A);
    check("burst wr strobe", {7'h00, sp}, 8'h00);
    m.close();
    m.send(8'hBF);
    check("fifo pulse", {7'h00, frp}, 8'h01);
    check("fifo data", bo, 8'h3C);
    m.send(8'h00);
    check("fifo once", {7'h00, frp}, 8'h00);
    check("fifo extra", bo, 8'h00);
    m.close();
  endtask
  task automatic t_reserved;
    wr1(8'h2F, 8'hFF);
    rd1(8'hAF, "resv 2f", 8'h00);
    rd1(8'hBE, "resv 3e", 8'h00);
    rd1(8'h81, "out1 kept", 8'h2A);
    rd1(8'h82, "ext rd", 8'h77);
  endtask
  task automatic t_freeze;
    // bytes sent with the enable low must not land
    ce = 1'b0;
    wr1(8'h01, 8'h80);
    check("ds frozen", {7'h00, ds}, 8'h00);
    ce = 1'b1;
    rd1(8'h81, "out1 frozen", 8'h2A);
  endtask
  task automatic t_rerun;
    // second reset in mid-run restores the pin configuration
    rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    rd1(8'h81, "out1 rerst", 8'h2E);
    check("oe1 rerst", {7'h00, g1n}, 8'h01);
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_write();
    t_burst();
    t_strobes();
    t_reserved();
    t_freeze();
    t_rerun();
    give_verdict();
  end
endmodule
